// ===== rtl/cond_set_halt_subtract_exec.sv
// Purpose: Decode and execute of set-on-condition, load-status-and-halt and subtract.
// Assumes: Operands are fetched outside; one instruction presented per strobe.
// Notes:   Results and exceptions are one-cycle pulses with registered data.
`timescale 1ns/1ns
`default_nettype none

module cond_set_halt_subtract_exec
    import exec_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              instr_valid,
    input  wire logic [15:0]       opcode,
    input  wire logic [15:0]       ext_word,
    input  wire logic [DATA_W-1:0] src_operand,
    input  wire logic [DATA_W-1:0] dst_operand,
    input  wire logic [2:0]        irq_level,
    output logic                   instr_ready,
    output logic                   halted,
    output logic [15:0]            processor_status_word,
    output logic                   pc_advance,
    output logic                   result_valid,
    output logic [DATA_W-1:0]      result_data,
    output logic [1:0]             result_size,
    output logic                   result_to_reg,
    output logic [2:0]             result_reg,
    output logic [5:0]             result_ea,
    output logic                   privilege_trap,
    output logic                   illegal_trap,
    output logic                   trace_trap,
    output logic                   irq_taken,
    output logic [2:0]             irq_taken_level
);
    // Operand ports and the fetch side are fixed at 32 bits
    if (DATA_W != 32) begin : g_width_chk
        $error("DATA_W must be 32");
    end

    // ========================================================================
    // State
    // ========================================================================
    typedef enum logic [1:0] {
        RUN  = 2'b01,
        HALT = 2'b10
    } mode_t;

    typedef struct packed {
        mode_t             mode;
        logic [15:0]       psw;
        logic              trace_pend;
        logic              pc_adv;
        logic              res_v;
        logic [DATA_W-1:0] res;
        logic [1:0]        res_sz;
        logic              res_to_reg;
        logic [2:0]        res_reg;
        logic [5:0]        res_ea;
        logic              priv;
        logic              ill;
        logic              trc;
        logic              irq;
        logic [2:0]        irq_lvl;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // ========================================================================
    // Decode
    // ========================================================================
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic [2:0] opm;
    logic [1:0] sub_sz;
    logic       is_set;
    logic       is_halt;
    logic       is_sub;
    logic       sub_to_mem;
    logic       data_alt;
    logic       mem_alt;
    logic       src_ok;
    logic       set_ok;
    logic       sub_ok;
    logic       cond_true;

    assign ea_mode    = opcode[MODE_HI:MODE_LO];
    assign ea_reg     = opcode[EREG_HI:EREG_LO];
    assign opm        = opcode[OPM_HI:OPM_LO];
    assign sub_sz     = opm[1:0];
    assign sub_to_mem = opm[OPM_DIR_BIT];
    assign is_halt    = opcode == HALT_OPCODE;
    assign is_set     = opcode[GROUP_HI:GROUP_LO] == SET_GROUP
                        && opcode[SIZE_HI:SIZE_LO] == SET_SIZE_CODE;
    assign is_sub     = opcode[GROUP_HI:GROUP_LO] == SUB_GROUP
                        && sub_sz != SZ_LONG + 2'h1;

    // Memory alterable: indirect through indexed, or absolute short/long
    assign mem_alt  = (ea_mode >= MODE_IND && ea_mode <= MODE_IDX)
                      || (ea_mode == MODE_EXT && (ea_reg == EXT_ABS_W || ea_reg == EXT_ABS_L));
    assign data_alt = mem_alt || ea_mode == MODE_DREG;
    assign src_ok   = ea_mode != MODE_EXT
                      || ea_reg <= EXT_IMM;
    assign set_ok   = data_alt;
    assign sub_ok   = sub_to_mem ? mem_alt
                      : (src_ok && !(ea_mode == MODE_AREG && sub_sz == SZ_BYTE));

    cond_eval u_cond (
        .cond    (opcode[COND_HI:COND_LO]),
        .flags   (st_r.psw[PSW_X:PSW_C]),
        .is_true (cond_true)
    );

    // ========================================================================
    // Subtract datapath
    // ========================================================================
    logic [DATA_W-1:0] minuend;
    logic [DATA_W-1:0] subtrahend;
    logic [DATA_W:0]   diff;
    logic              msb_d;
    logic              msb_s;
    logic              msb_r;
    logic              borrow;
    logic              zero;
    int                top;

    // Caller presents the minuend on dst_operand, so one subtractor serves both directions
    assign minuend    = dst_operand;
    assign subtrahend = src_operand;
    assign diff       = {1'b0, minuend} - {1'b0, subtrahend};

    always_comb begin
        top = 7;
        unique case (sub_sz)
            SZ_BYTE: top = 7;
            SZ_WORD: top = 15;
            default: top = DATA_W - 1;
        endcase
        msb_d  = minuend[top];
        msb_s  = subtrahend[top];
        msb_r  = diff[top];
        // Borrow out of the sized field: compare the sized operands
        unique case (sub_sz)
            SZ_BYTE: begin
                borrow = minuend[7:0] < subtrahend[7:0];
                zero   = diff[7:0] == 8'h00;
            end
            SZ_WORD: begin
                borrow = minuend[15:0] < subtrahend[15:0];
                zero   = diff[15:0] == 16'h0000;
            end
            default: begin
                borrow = diff[DATA_W];
                zero   = diff[DATA_W-1:0] == '0;
            end
        endcase
    end

    // ========================================================================
    // Next state
    // ========================================================================
    logic in_super;
    assign in_super = st_r.psw[PSW_SUPER];

    always_comb begin
        st_nxt            = st_r;
        st_nxt.pc_adv     = 1'b0;
        st_nxt.res_v      = 1'b0;
        st_nxt.priv       = 1'b0;
        st_nxt.ill        = 1'b0;
        st_nxt.trc        = 1'b0;
        st_nxt.irq        = 1'b0;
        unique case (st_r.mode)
            RUN: begin
                if (instr_valid) begin
                    if (is_halt) begin
                        if (!in_super) begin
                            st_nxt.priv = 1'b1;
                        end else begin
                            st_nxt.psw        = ext_word;
                            st_nxt.pc_adv     = 1'b1;
                            st_nxt.mode       = HALT;
                            st_nxt.trace_pend = st_r.psw[PSW_TRACE_LO] && !st_r.psw[PSW_TRACE_HI];
                        end
                    end else if (is_set) begin
                        if (!set_ok) begin
                            st_nxt.ill = 1'b1;
                        end else begin
                            st_nxt.res_v      = 1'b1;
                            st_nxt.res        = {{(DATA_W-8){1'b0}}, cond_true ? BYTE_ONES : BYTE_ZEROS};
                            st_nxt.res_sz     = SZ_BYTE;
                            st_nxt.res_to_reg = ea_mode == MODE_DREG;
                            st_nxt.res_reg    = ea_reg;
                            st_nxt.res_ea     = opcode[MODE_HI:EREG_LO];
                        end
                    end else if (is_sub) begin
                        if (!sub_ok) begin
                            st_nxt.ill = 1'b1;
                        end else begin
                            st_nxt.res_v      = 1'b1;
                            st_nxt.res        = diff[DATA_W-1:0];
                            st_nxt.res_sz     = sub_sz;
                            st_nxt.res_to_reg = !sub_to_mem;
                            st_nxt.res_reg    = opcode[DREG_HI:DREG_LO];
                            st_nxt.res_ea     = opcode[MODE_HI:EREG_LO];
                            st_nxt.psw[PSW_N] = msb_r;
                            st_nxt.psw[PSW_Z] = zero;
                            st_nxt.psw[PSW_V] = (msb_d != msb_s) && (msb_r != msb_d);
                            st_nxt.psw[PSW_C] = borrow;
                            st_nxt.psw[PSW_X] = borrow;
                        end
                    end else begin
                        st_nxt.ill = 1'b1;
                    end
                end
            end
            HALT: begin
                // Apart from reset, only trace or a high enough interrupt leaves this state
                if (st_r.trace_pend) begin
                    st_nxt.trc        = 1'b1;
                    st_nxt.trace_pend = 1'b0;
                    st_nxt.mode       = RUN;
                end else if (irq_level > st_r.psw[PSW_MASK_HI:PSW_MASK_LO]) begin
                    st_nxt.irq     = 1'b1;
                    st_nxt.irq_lvl = irq_level;
                    st_nxt.mode    = RUN;
                end
            end
        endcase
    end

    // Reset acts in every mode, halted included
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r            <= '0;
            st_r.mode       <= RUN;
            st_r.psw        <= PSW_RESET;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign instr_ready           = st_r.mode == RUN;
    assign halted                = st_r.mode == HALT;
    assign processor_status_word = st_r.psw;
    assign pc_advance            = st_r.pc_adv;
    assign result_valid          = st_r.res_v;
    assign result_data           = st_r.res;
    assign result_size           = st_r.res_sz;
    assign result_to_reg         = st_r.res_to_reg;
    assign result_reg            = st_r.res_reg;
    assign result_ea             = st_r.res_ea;
    assign privilege_trap        = st_r.priv;
    assign illegal_trap          = st_r.ill;
    assign trace_trap            = st_r.trc;
    assign irq_taken             = st_r.irq;
    assign irq_taken_level       = st_r.irq_lvl;

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    halt_load_a: assert property (clk_en && instr_ready && instr_valid && is_halt && in_super
                                  |=> halted && processor_status_word == $past(ext_word) && pc_advance)
        else $error("halt did not load status and stop");
    priv_trap_a: assert property (clk_en && instr_ready && instr_valid && is_halt && !in_super
                                  |=> privilege_trap && !halted)
        else $error("user halt not trapped");
    set_byte_a: assert property (result_valid && $past(is_set) |-> result_data[7:0] == BYTE_ONES
                                 || result_data[7:0] == BYTE_ZEROS)
        else $error("set result not all ones or zeros");
    set_flags_a: assert property (clk_en && instr_ready && instr_valid && is_set
                                  |=> processor_status_word[PSW_X:PSW_C] == $past(st_r.psw[PSW_X:PSW_C]))
        else $error("set changed flags");
    set_mode_a: assert property (clk_en && instr_ready && instr_valid && is_set && ea_mode == MODE_AREG
                                 |=> illegal_trap)
        else $error("set to address register not illegal");
    byte_areg_a: assert property (clk_en && instr_ready && instr_valid && is_sub && !sub_to_mem
                                  && sub_sz == SZ_BYTE && ea_mode == MODE_AREG |=> illegal_trap)
        else $error("byte address source accepted");
    sub_dest_a: assert property (clk_en && instr_ready && instr_valid && is_sub && sub_to_mem
                                 && ea_mode == MODE_DREG |=> illegal_trap && !result_valid)
        else $error("register destination accepted");
    extend_carry_a: assert property (clk_en && instr_ready && instr_valid && is_sub && sub_ok
                                     |=> processor_status_word[PSW_X] == processor_status_word[PSW_C])
        else $error("extend differs from carry");
    halt_stay_a: assert property (halted && clk_en && !st_r.trace_pend
                                  && irq_level <= st_r.psw[PSW_MASK_HI:PSW_MASK_LO] |=> halted)
        else $error("left halt without cause");

    halt_c:  cover property (halted ##1 irq_taken);
    trace_c: cover property (halted ##1 trace_trap);
    sub_c:   cover property (result_valid && processor_status_word[PSW_C]);
endmodule : cond_set_halt_subtract_exec
`default_nettype wire

// ===== rtl/exec_pkg.sv
// Purpose: Shared constants for the set-on-condition, halt and subtract executor.
// Assumes: 16-bit opcode words, 16-bit status word, 32-bit operands.
// Notes:   Field positions, encodings and status bit positions live here only.
package exec_pkg;
    // ========================================================================
    // Opcode fields
    // ========================================================================
    localparam logic [15:0] HALT_OPCODE    = 16'h4E72;
    localparam logic [3:0]  SUB_GROUP      = 4'hD;
    localparam logic [3:0]  SET_GROUP      = 4'h5;
    localparam logic [1:0]  SET_SIZE_CODE  = 2'h3;
    localparam int          GROUP_HI       = 15;
    localparam int          GROUP_LO       = 12;
    localparam int          COND_HI        = 11;
    localparam int          COND_LO        = 8;
    localparam int          DREG_HI        = 11;
    localparam int          DREG_LO        = 9;
    localparam int          OPM_HI         = 8;
    localparam int          OPM_LO         = 6;
    localparam int          SIZE_HI        = 7;
    localparam int          SIZE_LO        = 6;
    localparam int          MODE_HI        = 5;
    localparam int          MODE_LO        = 3;
    localparam int          EREG_HI        = 2;
    localparam int          EREG_LO        = 0;

    // ========================================================================
    // Addressing modes
    // ========================================================================
    localparam logic [2:0] MODE_DREG    = 3'h0;
    localparam logic [2:0] MODE_AREG    = 3'h1;
    localparam logic [2:0] MODE_IND     = 3'h2;
    localparam logic [2:0] MODE_IDX     = 3'h6;
    localparam logic [2:0] MODE_EXT     = 3'h7;
    localparam logic [2:0] EXT_ABS_W    = 3'h0;
    localparam logic [2:0] EXT_ABS_L    = 3'h1;
    localparam logic [2:0] EXT_PC_DISP  = 3'h2;
    localparam logic [2:0] EXT_PC_IDX   = 3'h3;
    localparam logic [2:0] EXT_IMM      = 3'h4;

    // ========================================================================
    // Subtract operation modes and sizes
    // ========================================================================
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam int         OPM_DIR_BIT = 2;

    // ========================================================================
    // Condition codes
    // ========================================================================
    localparam logic [3:0] CC_T  = 4'h0;
    localparam logic [3:0] CC_F  = 4'h1;
    localparam logic [3:0] CC_HI = 4'h2;
    localparam logic [3:0] CC_LS = 4'h3;
    localparam logic [3:0] CC_CC = 4'h4;
    localparam logic [3:0] CC_CS = 4'h5;
    localparam logic [3:0] CC_NE = 4'h6;
    localparam logic [3:0] CC_EQ = 4'h7;
    localparam logic [3:0] CC_VC = 4'h8;
    localparam logic [3:0] CC_VS = 4'h9;
    localparam logic [3:0] CC_PL = 4'hA;
    localparam logic [3:0] CC_MI = 4'hB;
    localparam logic [3:0] CC_GE = 4'hC;
    localparam logic [3:0] CC_LT = 4'hD;
    localparam logic [3:0] CC_GT = 4'hE;
    localparam logic [3:0] CC_LE = 4'hF;

    // ========================================================================
    // Status word layout
    // ========================================================================
    localparam int          PSW_C        = 0;
    localparam int          PSW_V        = 1;
    localparam int          PSW_Z        = 2;
    localparam int          PSW_N        = 3;
    localparam int          PSW_X        = 4;
    localparam int          PSW_MASK_LO  = 8;
    localparam int          PSW_MASK_HI  = 10;
    localparam int          PSW_SUPER    = 13;
    localparam int          PSW_TRACE_LO = 14;
    localparam int          PSW_TRACE_HI = 15;
    localparam logic [15:0] PSW_RESET    = 16'h2700;
    localparam logic [7:0]  BYTE_ONES    = 8'hFF;
    localparam logic [7:0]  BYTE_ZEROS   = 8'h00;
endpackage : exec_pkg

// ===== rtl/cond_eval.sv
// Purpose: Evaluates one 4-bit condition selector against the flags.
// Assumes: Flags are the low five bits of the status word.
// Notes:   Pure combinational.
`timescale 1ns/1ns
`default_nettype none
module cond_eval
    import exec_pkg::*;
(
    input  wire logic [3:0] cond,
    input  wire logic [4:0] flags,
    output logic            is_true
);
    logic c;
    logic v;
    logic z;
    logic n;
    assign c = flags[PSW_C];
    assign v = flags[PSW_V];
    assign z = flags[PSW_Z];
    assign n = flags[PSW_N];

    always_comb begin
        unique case (cond)
            CC_T:    is_true = 1'b1;
            CC_F:    is_true = 1'b0;
            CC_HI:   is_true = !c && !z;
            CC_LS:   is_true = c || z;
            CC_CC:   is_true = !c;
            CC_CS:   is_true = c;
            CC_NE:   is_true = !z;
            CC_EQ:   is_true = z;
            CC_VC:   is_true = !v;
            CC_VS:   is_true = v;
            CC_PL:   is_true = !n;
            CC_MI:   is_true = n;
            CC_GE:   is_true = n == v;
            CC_LT:   is_true = n != v;
            CC_GT:   is_true = (n == v) && !z;
            CC_LE:   is_true = z || (n != v);
        endcase
    end
endmodule : cond_eval
`default_nettype wire

// ===== bench/fetch_model.sv
// Purpose: Instruction stream and operand source in front of the executor.
// Assumes: One instruction is offered per go pulse and held until taken.
// Notes:   Fields that have been taken are inverted so stale values cannot match.
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic [15:0] op_in,
    input  wire logic [15:0] ext_in,
    input  wire logic [31:0] src_in,
    input  wire logic [31:0] dst_in,
    input  wire logic        instr_ready,
    output logic             instr_valid,
    output logic [15:0]      opcode,
    output logic [15:0]      ext_word,
    output logic [31:0]      src_operand,
    output logic [31:0]      dst_operand
);
    // ========================================
    // Offer and release
    // ========================================
    initial begin
        instr_valid = 1'b0;
        opcode      = 16'h0000;
        ext_word    = 16'h0000;
        src_operand = 32'h0;
        dst_operand = 32'h0;
    end
    always @(posedge ref_clk) begin
        if (go) begin
            instr_valid <= 1'b1;
            opcode      <= op_in;
            ext_word    <= ext_in;
            src_operand <= src_in;
            dst_operand <= dst_in;
        end else if (instr_valid && instr_ready) begin
            instr_valid <= 1'b0;
            opcode      <= ~opcode;
            ext_word    <= ~ext_word;
            src_operand <= ~src_operand;
            dst_operand <= ~dst_operand;
        end
    end
endmodule : fetch_model
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the set, halt and subtract executor.
// Assumes: Interrupt entry leaves the status word as the halt loaded it.
// Notes:   Each scenario task issues through the fetch model and judges the pulses.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import exec_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        go      = 1'b0;
    logic [15:0] op_in   = 16'h0000;
    logic [15:0] ext_in  = 16'h0000;
    logic [31:0] src_in  = 32'h0;
    logic [31:0] dst_in  = 32'h0;
    logic [2:0]  irq_level = 3'h0;
    logic        clk_en    = 1'b1;
    logic        instr_valid, instr_ready, halted, pc_advance, result_valid, result_to_reg;
    logic        privilege_trap, illegal_trap, trace_trap, irq_taken;
    logic [15:0] opcode, ext_word, processor_status_word;
    logic [31:0] src_operand, dst_operand, result_data;
    logic [2:0]  result_reg, irq_taken_level;
    logic [1:0]  result_size;
    logic [5:0]  result_ea;
    logic [4:0]  got;
    int          fails = 0;
    int          checks_done = 0;

    always #5 ref_clk = ~ref_clk;
    fetch_model PTN (.ref_clk, .go, .op_in, .ext_in, .src_in, .dst_in, .instr_ready, .instr_valid,
        .opcode, .ext_word, .src_operand, .dst_operand);
    cond_set_halt_subtract_exec DUT (.ref_clk, .reset, .clk_en, .instr_valid, .opcode, .ext_word,
        .src_operand, .dst_operand, .irq_level, .instr_ready, .halted, .processor_status_word, .pc_advance,
        .result_valid, .result_data, .result_size, .result_to_reg, .result_reg, .result_ea,
        .privilege_trap, .illegal_trap, .trace_trap, .irq_taken, .irq_taken_level);

    // ========================================
    // Shared tasks
    // ========================================
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic issue(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] s, input logic [31:0] d);
        @(posedge ref_clk);
        go     <= 1'b1;
        op_in  <= op;
        ext_in <= ext;
        src_in <= s;
        dst_in <= d;
        @(posedge ref_clk);
        go  <= 1'b0;
        got = '0;
        repeat (6) begin
            @(negedge ref_clk);
            got |= {result_valid, illegal_trap, privilege_trap, pc_advance, trace_trap};
        end
    endtask : issue
    task automatic irq_wait(input logic [2:0] lvl);
        @(posedge ref_clk);
        irq_level <= lvl;
        got = '0;
        repeat (4) begin
            @(negedge ref_clk);
            got[0] |= irq_taken;
        end
    endtask : irq_wait

    // ========================================
    // Scenarios
    // ========================================
    task automatic t_sub;
        issue(16'hD110, 16'h0, 32'h1, 32'h80);
        chk({result_data[7:0], result_to_reg, result_ea, result_size}, {8'h7F, 1'b0, 6'h10, SZ_BYTE});
        chk(processor_status_word[4:0], 5'h02);
        issue(16'hD080, 16'h0, 32'h12345678, 32'h12345678);
        chk({got, result_data}, {5'h10, 32'h0});
        chk(processor_status_word[4:0], 5'h04);
        issue(16'hD07C, 16'h0, 32'h1, 32'h3);
        chk({got, result_data[15:0]}, {5'h10, 16'h0002});
        issue(16'hD240, 16'h0, 32'h7, 32'h5);
        chk({result_data[15:0], result_to_reg, result_reg, result_size}, {16'hFFFE, 1'b1, 3'h1, SZ_WORD});
        chk(processor_status_word[4:0], 5'h19);
    endtask : t_sub
    task automatic t_set;
        logic [15:0] truth;
        truth = 16'b1010_1001_0110_1001;
        for (int cc = 0; cc < 16; cc++) begin
            issue({SET_GROUP, cc[3:0], SET_SIZE_CODE, MODE_IND, cc[2:0]}, 16'h0, 32'h0, 32'h0);
            chk(result_data, truth[cc] ? 32'hFF : 32'h0);
            chk({result_ea, processor_status_word[4:0]}, {MODE_IND, cc[2:0], 5'h19});
        end
    endtask : t_set
    task automatic t_illegal;
        logic [15:0] ops [11] = '{16'hD008, 16'hD100, 16'hD17C, 16'h50C8, 16'h50FC, 16'h50FA,
                                  16'hD0C0, 16'hD03D, 16'h4E71, 16'h50C3, 16'h50F9};
        for (int i = 0; i < 11; i++) begin
            issue(ops[i], 16'h0, 32'h3, 32'h9);
            chk(got, i < 9 ? 5'h08 : 5'h10);
            chk(processor_status_word[4:0], 5'h19);
        end
    endtask : t_illegal
    task automatic t_halt;
        issue(HALT_OPCODE, 16'h6500, 32'h0, 32'h0);
        chk({got, halted, instr_ready, processor_status_word}, {5'h02, 2'b10, 16'h6500});
        irq_wait(3'h5);
        chk({got[0], halted}, 2'b01);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        irq_wait(3'h6);
        chk({got[0], halted}, 2'b01);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        irq_wait(3'h6);
        chk({got[0], irq_taken_level, halted}, {1'b1, 3'h6, 1'b0});
        irq_wait(3'h0);
        issue(HALT_OPCODE, 16'h2000, 32'h0, 32'h0);
        chk({got, halted, processor_status_word}, {5'h03, 1'b0, 16'h2000});
    endtask : t_halt
    task automatic t_reset_halt;
        issue(HALT_OPCODE, 16'h271F, 32'h0, 32'h0);
        irq_wait(3'h7);
        chk({got[0], halted}, 2'b01);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({halted, processor_status_word}, {1'b0, PSW_RESET});
        reset     <= 1'b0;
        irq_level <= 3'h0;
    endtask : t_reset_halt
    task automatic t_priv;
        issue(HALT_OPCODE, 16'h0300, 32'h0, 32'h0);
        irq_wait(3'h4);
        chk({got[0], halted}, 2'b10);
        irq_wait(3'h0);
        issue(HALT_OPCODE, 16'h2700, 32'h0, 32'h0);
        chk({got, halted, processor_status_word}, {5'h04, 1'b0, 16'h0300});
    endtask : t_priv

    task automatic print_verdict;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // ========================================
    // Main sequence and watchdog
    // ========================================
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        chk(processor_status_word, PSW_RESET);
        t_sub();
        t_set();
        t_illegal();
        t_halt();
        t_reset_halt();
        t_priv();
        print_verdict();
    end
    initial begin
        // Whole run is a few hundred cycles; this leaves ample margin
        #200000;
        fails++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
